// *** core/dmmu_mul16.sv ***
// Shared 16-by-16 multiplier with per-operand signedness and the
// fractional left-shift correction.
// Assumes its operands are stable within the cycle; it holds no state.
`timescale 1ns/1ps
`default_nettype none
`include "dmmu_params.svh"
module dmmu_mul16 (
    // Operands in, product out.
    dmmu_mul_if.mul mi
);
    logic signed [16:0] a_x;
    logic signed [16:0] b_x;
    logic signed [33:0] raw;
    logic min_sq;

    // A 17-bit extension lets one signed multiplier serve all sign mixes.
    always_comb begin
        a_x = {mi.sgn_a & mi.a[15], mi.a};
        b_x = {mi.sgn_b & mi.b[15], mi.b};
        raw = a_x * b_x;
        min_sq = mi.shift & (mi.a == `DMMU_FRAC_MIN) & (mi.b == `DMMU_FRAC_MIN);
        if (min_sq) begin
            mi.prod = `DMMU_FRAC_MAX_PROD; // RQ17
        end else if (mi.shift) begin
            mi.prod = {raw[32:0], 1'b0}; // RQ12
        end else begin
            mi.prod = raw;
        end
    end
endmodule
`default_nettype wire

// *** core/dmmu_mul_if.sv ***
// Operand and product bundle between the datapath and its multiplier.
// Assumes both ends run combinationally in one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface dmmu_mul_if;
    logic [15:0] a;
    logic [15:0] b;
    logic sgn_a;
    logic sgn_b;
    logic shift;
    logic [33:0] prod;
    modport core (output a, b, sgn_a, sgn_b, shift, input prod);
    modport mul (input a, b, sgn_a, sgn_b, shift, output prod);
endinterface
`default_nettype wire

// *** core/dmmu_params.svh ***
// Constants of the dual multiply-accumulate datapath: register offsets,
// field positions and saturation limits.
// Assumes it is included by bare name from files under core/.
`ifndef DMMU_PARAMS_SVH
`define DMMU_PARAMS_SVH

// -----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// -----------------------------------------------------------------
`define DMMU_OFF_CTRL 6'h00
`define DMMU_OFF_FLAGS 6'h04
`define DMMU_OFF_IRQ_STAT 6'h08
`define DMMU_OFF_IRQ_CLR 6'h0c
`define DMMU_OFF_IRQ_EN 6'h10
`define DMMU_OFF_ACC0_LO 6'h14
`define DMMU_OFF_ACC0_HI 6'h18
`define DMMU_OFF_ACC1_LO 6'h1c
`define DMMU_OFF_ACC1_HI 6'h20

// -----------------------------------------------------------------
// Field positions and widths
// -----------------------------------------------------------------
`define DMMU_CTRL_RND_BIT 0
`define DMMU_FLAG_SAT_BIT 0
`define DMMU_FLAG_STICKY_BIT 1
`define DMMU_FLAG_ACC0_BIT 2
`define DMMU_FLAG_ACC1_BIT 3
`define DMMU_EV_W 3

// -----------------------------------------------------------------
// Limits, as 42-bit two's complement working values; the fraction constants are 16 and 34 bits
// -----------------------------------------------------------------
`define DMMU_ZERO 42'h00000000000
`define DMMU_S16_MIN 42'h3ffffff8000
`define DMMU_S16_MAX 42'h00000007fff
`define DMMU_S32_MIN 42'h3ff80000000
`define DMMU_S32_MAX 42'h0007fffffff
`define DMMU_U32_MAX 42'h000ffffffff
`define DMMU_S40_MIN 42'h38000000000
`define DMMU_S40_MAX 42'h07fffffffff
`define DMMU_U40_MAX 42'h0ffffffffff
`define DMMU_RND_HALF 42'h00000008000
`define DMMU_FRAC_MIN 16'h8000
`define DMMU_FRAC_MAX_PROD 34'h0007fffffff

`endif

// *** core/dmmu_pkg.sv ***
// Types shared by the multiply datapath modules.
// Assumes nothing of its surroundings.
package dmmu_pkg;
    typedef enum logic [1:0] {
        DMMU_K_MUL16_HALF,
        DMMU_K_MUL16_WORD,
        DMMU_K_MUL32,
        DMMU_K_MACC
    } dmmu_kind_t;
    typedef enum logic [2:0] {
        DMMU_M_DEFAULT,
        DMMU_M_UNSIGNED_FRAC,
        DMMU_M_SIGNED_INTEGER,
        DMMU_M_INT_DOUBLED,
        DMMU_M_INT_UPPER_HALF,
        DMMU_M_FRAC_SAT_AT_BIT31
    } dmmu_mode_t;
    typedef enum logic [1:0] {
        DMMU_A_LOAD,
        DMMU_A_ADD,
        DMMU_A_SUB
    } dmmu_accop_t;
endpackage

// *** core/dmmu_top.sv ***
// Dual multiply-accumulate datapath: 16-bit multiplies to half or full
// registers, the 32-by-32 modulo multiply and accumulator updates.
// Assumes the decoder issues one operation per cycle, already picks the
// operand halves, and writes results back to the register file itself.
//
// Notes on behaviour
// (RQ1) Integer-doubled half result: low 16 product bits doubled, saturated signed 16.
// (RQ2) Integer-doubled word result: product doubled, saturated to signed 32.
// (RQ3) Integer upper-half: round product at bit 16, saturate, keep top half.
// (RQ4) Mixed-sign option only on unit 1, without shift correction.
// (RQ5) Mixed-sign: first operand signed, second unsigned; rest per mode.
// (RQ6) 16-bit multiplies set or clear saturation flag; sticky follows sets.
// (RQ7) The 32-by-32 multiply returns the product modulo two to the 32.
// (RQ8) The 32-by-32 multiply touches no status bit.
// (RQ9) The 32-by-32 multiply leaves both accumulators alone.
// (RQ10) The 32-by-32 multiply is issued alone.
// (RQ11) Accumulator multiply loads, adds or subtracts into its unit's accumulator.
// (RQ12) Default accumulate: shift-corrected signed fraction, signed 40-bit saturation.
// (RQ13) Unsigned accumulate: zero-extended product, saturation floor at zero.
// (RQ14) Signed integer accumulate: sign-extended product, signed 40-bit saturation.
// (RQ15) Bit-31 fraction format saturates the accumulator to the 1.31 range.
// (RQ16) Mixed with bit-31 format: both units saturate at 32 bits.
// (RQ17) Most negative fraction squared becomes the largest positive fraction.
// (RQ18) A control bit picks biased or unbiased rounding to 16 bits.
// (RQ19) Rounding adds half an LSB; unbiased ties go to even.
`timescale 1ns/1ps
`default_nettype none
`include "dmmu_params.svh"
module dmmu_top
    import dmmu_pkg::*;
(
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Issue port from the instruction decoder.
    input wire logic OP_VALID,
    input wire logic [1:0] OP_KIND,
    input wire logic [2:0] OP_MODE,
    input wire logic [1:0] OP_ACC,
    input wire logic OP_UNIT,
    input wire logic OP_MIXED,
    input wire logic [31:0] OP_SRC0,
    input wire logic [31:0] OP_SRC1,
    // Result toward the data register file.
    output logic RES_VALID,
    output logic RES_HALF,
    output logic RES_UNIT,
    output logic [31:0] RES_DATA,
    // Avalon-MM register slave.
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Interrupt.
    output logic IRQ
);

    // -----------------------------------------------------------------
    // Helper functions
    // -----------------------------------------------------------------

    // Clamp a 42-bit signed value into [lo, hi].
    function automatic logic [41:0] dmmu_clamp(input logic [41:0] x,
                                               input logic [41:0] lo,
                                               input logic [41:0] hi);
        if ($signed(x) < $signed(lo)) begin
            return lo;
        end
        if ($signed(x) > $signed(hi)) begin
            return hi;
        end
        return x;
    endfunction

    // Round at bit 16; an exact tie with bit 16 clear stays put when
    // unbiased, so ties always land on an even upper half.
    function automatic logic [41:0] dmmu_round16(input logic [41:0] x,
                                                 input logic biased);
        if (!biased && x[16:0] == 17'h08000) begin
            return x; // RQ19
        end
        return x + `DMMU_RND_HALF; // RQ19
    endfunction

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    dmmu_kind_t kind;
    dmmu_mode_t mode;
    dmmu_accop_t accop;
    logic mixed, fu, intm, is_16;
    logic [41:0] p, x, lo, hi, y;
    logic upper, rnd, rsat;
    logic [31:0] rdata, mul32_w;
    logic [39:0] acc_sel;
    logic [41:0] acc_x, m, mlo, mhi, mac_y;
    logic macsat;
    logic [`DMMU_EV_W-1:0] ev;
    logic res_valid_r, res_valid_nxt, res_half_r, res_half_nxt;
    logic res_unit_r, res_unit_nxt;
    logic [31:0] res_r, res_nxt;
    logic sat_r, sat_nxt, sticky_r, sticky_nxt;
    logic av0_r, av0_nxt, av1_r, av1_nxt;
    logic [39:0] acc0_r, acc0_nxt, acc1_r, acc1_nxt;
    logic done_r, done_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic rnd_r, rnd_nxt;
    logic [`DMMU_EV_W-1:0] en_r, en_nxt, st_r, st_nxt;
    logic wr, sticky_clr;

    dmmu_mul_if mi();

    dmmu_mul16 u_mul (
        .mi(mi.mul)
    );

    // -----------------------------------------------------------------
    // Operand decode
    // -----------------------------------------------------------------

    // The mixed-sign request is dropped on unit 0 rather than faulted.
    always_comb begin
        kind = dmmu_kind_t'(OP_KIND);
        mode = dmmu_mode_t'(OP_MODE);
        accop = dmmu_accop_t'(OP_ACC);
        mixed = OP_MIXED & OP_UNIT; // RQ4
        fu = (mode == DMMU_M_UNSIGNED_FRAC);
        intm = (mode == DMMU_M_SIGNED_INTEGER) | (mode == DMMU_M_INT_DOUBLED)
             | (mode == DMMU_M_INT_UPPER_HALF);
        is_16 = OP_VALID & ((kind == DMMU_K_MUL16_HALF) | (kind == DMMU_K_MUL16_WORD));
    end

    // Mixed: first operand signed, second unsigned, never shift-corrected.
    assign mi.a = OP_SRC0[15:0];
    assign mi.b = OP_SRC1[15:0];
    assign mi.sgn_a = mixed | ~fu; // RQ5
    assign mi.sgn_b = ~fu & ~mixed; // RQ5
    assign mi.shift = ~fu & ~intm & ~mixed; // RQ4
    assign p = {{8{mi.prod[33]}}, mi.prod};
    assign mul32_w = 32'(OP_SRC0 * OP_SRC1);

    // -----------------------------------------------------------------
    // Register-file results of the 16-bit multiply
    // -----------------------------------------------------------------

    // Pick the pre-saturation value and limits, round, then clamp once.
    always_comb begin
        x = p;
        lo = `DMMU_S32_MIN;
        hi = `DMMU_S32_MAX;
        upper = 1'b0;
        rnd = 1'b0;
        if (kind == DMMU_K_MUL16_HALF) begin
            case (mode)
                DMMU_M_UNSIGNED_FRAC: begin
                    lo = `DMMU_ZERO;
                    hi = `DMMU_U32_MAX;
                    upper = 1'b1;
                    rnd = 1'b1;
                end
                DMMU_M_SIGNED_INTEGER: begin
                    lo = `DMMU_S16_MIN;
                    hi = `DMMU_S16_MAX;
                end
                DMMU_M_INT_DOUBLED: begin
                    x = {{25{p[15]}}, p[15:0], 1'b0}; // RQ1
                    lo = `DMMU_S16_MIN;
                    hi = `DMMU_S16_MAX;
                end
                default: begin
                    upper = 1'b1; // RQ3
                    rnd = 1'b1;
                end
            endcase
        end else begin
            case (mode)
                DMMU_M_UNSIGNED_FRAC: begin
                    lo = `DMMU_ZERO;
                    hi = `DMMU_U32_MAX;
                end
                DMMU_M_INT_DOUBLED: begin
                    x = {p[40:0], 1'b0}; // RQ2
                end
                default: begin
                end
            endcase
        end
        if (rnd) begin
            x = dmmu_round16(x, rnd_r); // RQ18
        end
        y = dmmu_clamp(x, lo, hi);
        rsat = (y != x); // RQ6
        if (upper) begin
            rdata = {16'h0000, y[31:16]}; // RQ3
        end else if (kind == DMMU_K_MUL16_HALF) begin
            rdata = {16'h0000, y[15:0]}; // RQ1
        end else begin
            rdata = y[31:0]; // RQ2
        end
    end

    // -----------------------------------------------------------------
    // Accumulator update
    // -----------------------------------------------------------------

    // A 42-bit sum holds any 40-bit accumulator plus a 34-bit product.
    always_comb begin
        acc_sel = OP_UNIT ? acc1_r : acc0_r; // RQ11
        acc_x = fu ? {2'b00, acc_sel} : {{2{acc_sel[39]}}, acc_sel}; // RQ13
        case (accop)
            DMMU_A_ADD: m = acc_x + p; // RQ11
            DMMU_A_SUB: m = acc_x - p;
            default: m = p;
        endcase
        case (mode)
            DMMU_M_UNSIGNED_FRAC: begin
                mlo = `DMMU_ZERO; // RQ13
                mhi = `DMMU_U40_MAX;
            end
            DMMU_M_FRAC_SAT_AT_BIT31: begin
                mlo = `DMMU_S32_MIN; // RQ15 RQ16
                mhi = `DMMU_S32_MAX;
            end
            default: begin
                mlo = `DMMU_S40_MIN; // RQ12 RQ14
                mhi = `DMMU_S40_MAX;
            end
        endcase
        mac_y = dmmu_clamp(m, mlo, mhi);
        macsat = (mac_y != m);
    end

    // -----------------------------------------------------------------
    // Datapath state
    // -----------------------------------------------------------------

    // Only the decoder's single issue slot exists, so the 32-bit
    // multiply can never overlap another operation here.
    always_comb begin
        res_valid_nxt = OP_VALID & (kind != DMMU_K_MACC); // RQ10
        res_half_nxt = res_half_r;
        res_unit_nxt = res_unit_r;
        res_nxt = res_r;
        sat_nxt = sat_r;
        av0_nxt = av0_r;
        av1_nxt = av1_r;
        acc0_nxt = acc0_r;
        acc1_nxt = acc1_r;
        ev = '0;
        if (res_valid_nxt) begin
            res_half_nxt = (kind == DMMU_K_MUL16_HALF);
            res_unit_nxt = OP_UNIT;
            res_nxt = (kind == DMMU_K_MUL32) ? mul32_w : rdata; // RQ7
        end
        if (is_16) begin
            sat_nxt = rsat; // RQ6
            ev[0] = rsat;
        end
        if (OP_VALID && kind == DMMU_K_MACC) begin
            if (OP_UNIT) begin
                acc1_nxt = mac_y[39:0]; // RQ11
                av1_nxt = macsat;
                ev[2] = macsat;
            end else begin
                acc0_nxt = mac_y[39:0]; // RQ11
                av0_nxt = macsat;
                ev[1] = macsat;
            end
        end
        sticky_nxt = (sticky_r & ~sticky_clr) | (is_16 & rsat); // RQ6
    end

    // Registers of the datapath.
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            res_valid_r <= 1'b0;
            res_half_r <= 1'b0;
            res_unit_r <= 1'b0;
            res_r <= 32'h0000_0000;
            sat_r <= 1'b0;
            sticky_r <= 1'b0;
            av0_r <= 1'b0;
            av1_r <= 1'b0;
            acc0_r <= 40'h00_0000_0000;
            acc1_r <= 40'h00_0000_0000;
        end else begin
            res_valid_r <= res_valid_nxt;
            res_half_r <= res_half_nxt;
            res_unit_r <= res_unit_nxt;
            res_r <= res_nxt;
            sat_r <= sat_nxt;
            sticky_r <= sticky_nxt;
            av0_r <= av0_nxt;
            av1_r <= av1_nxt;
            acc0_r <= acc0_nxt;
            acc1_r <= acc1_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Avalon-MM slave and interrupt
    // -----------------------------------------------------------------

    // One wait cycle per access; read data are captured in it.
    always_comb begin
        done_nxt = (AVS_READ | AVS_WRITE) & ~done_r;
        wr = AVS_WRITE & done_r;
        rd_nxt = rd_r;
        if (AVS_READ && !done_r) begin
            case (AVS_ADDRESS)
                `DMMU_OFF_CTRL: rd_nxt = {31'h0, rnd_r};
                `DMMU_OFF_FLAGS: rd_nxt = {28'h0, av1_r, av0_r, sticky_r, sat_r};
                `DMMU_OFF_IRQ_STAT: rd_nxt = {29'h0, st_r};
                `DMMU_OFF_IRQ_EN: rd_nxt = {29'h0, en_r};
                `DMMU_OFF_ACC0_LO: rd_nxt = acc0_r[31:0];
                `DMMU_OFF_ACC0_HI: rd_nxt = {24'h0, acc0_r[39:32]};
                `DMMU_OFF_ACC1_LO: rd_nxt = acc1_r[31:0];
                `DMMU_OFF_ACC1_HI: rd_nxt = {24'h0, acc1_r[39:32]};
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
        sticky_clr = wr & (AVS_ADDRESS == `DMMU_OFF_FLAGS)
                   & AVS_WRITEDATA[`DMMU_FLAG_STICKY_BIT];
        rnd_nxt = rnd_r;
        en_nxt = en_r;
        if (wr && AVS_ADDRESS == `DMMU_OFF_CTRL) begin
            rnd_nxt = AVS_WRITEDATA[`DMMU_CTRL_RND_BIT]; // RQ18
        end
        if (wr && AVS_ADDRESS == `DMMU_OFF_IRQ_EN) begin
            en_nxt = AVS_WRITEDATA[`DMMU_EV_W-1:0];
        end
        // A new event beats a clear written in the same cycle.
        st_nxt = st_r | ev;
        if (wr && AVS_ADDRESS == `DMMU_OFF_IRQ_CLR) begin
            st_nxt = (st_r & ~AVS_WRITEDATA[`DMMU_EV_W-1:0]) | ev;
        end
    end

    // Registers of the slave.
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            done_r <= 1'b0;
            rd_r <= 32'h0000_0000;
            rnd_r <= 1'b1;
            en_r <= '0;
            st_r <= '0;
        end else begin
            done_r <= done_nxt;
            rd_r <= rd_nxt;
            rnd_r <= rnd_nxt;
            en_r <= en_nxt;
            st_r <= st_nxt;
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~done_r;
    assign AVS_READDATA = rd_r;
    assign IRQ = |(st_r & en_r);
    assign RES_VALID = res_valid_r;
    assign RES_HALF = res_half_r;
    assign RES_UNIT = res_unit_r;
    assign RES_DATA = res_r;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_mul32;
        OP_VALID && OP_KIND == DMMU_K_MUL32;
    endsequence

    property p_mul32_mod;
        s_mul32 |=> RES_VALID && RES_DATA == $past(mul32_w);
    endproperty
    a_mul32_mod: assert property (p_mul32_mod) // RQ7
        else $error("Modulo product missing after the 32-bit multiply.");

    property p_mul32_flags;
        s_mul32 |=> $stable(sat_r) && $stable(av0_r) && $stable(av1_r);
    endproperty
    a_mul32_flags: assert property (p_mul32_flags) // RQ8
        else $error("The 32-bit multiply changed a status bit.");

    property p_mul32_acc;
        s_mul32 |=> $stable(acc0_r) && $stable(acc1_r);
    endproperty
    a_mul32_acc: assert property (p_mul32_acc) // RQ9
        else $error("The 32-bit multiply changed an accumulator.");

    property p_sat_set;
        is_16 && rsat |=> sat_r && sticky_r;
    endproperty
    a_sat_set: assert property (p_sat_set) // RQ6
        else $error("Saturation did not set both flags.");

    property p_frac_min;
        OP_VALID && OP_KIND == DMMU_K_MUL16_HALF && OP_MODE == DMMU_M_DEFAULT
            && OP_SRC0[15:0] == 16'h8000 && OP_SRC1[15:0] == 16'h8000
            |=> RES_DATA[15:0] == 16'h7fff;
    endproperty
    a_frac_min: assert property (p_frac_min) // RQ17
        else $error("Most negative fraction squared not saturated.");

    property p_int_doubled;
        OP_VALID && OP_KIND == DMMU_K_MUL16_HALF && OP_MODE == DMMU_M_INT_DOUBLED
            && OP_SRC0[15:0] == 16'h0001 && OP_SRC1[15:0] == 16'h4000
            |=> RES_DATA[15:0] == 16'h7fff && sat_r;
    endproperty
    a_int_doubled: assert property (p_int_doubled) // RQ1
        else $error("Doubled integer half result not saturated.");

    property p_tie_even;
        OP_VALID && OP_KIND == DMMU_K_MUL16_HALF && OP_MODE == DMMU_M_INT_UPPER_HALF
            && !rnd_r && OP_SRC0[15:0] == 16'h0280 && OP_SRC1[15:0] == 16'h0100
            |=> RES_DATA[15:0] == 16'h0002;
    endproperty
    a_tie_even: assert property (p_tie_even) // RQ19
        else $error("Unbiased tie did not round to even.");

    property p_w32_range;
        OP_VALID && OP_KIND == DMMU_K_MACC && OP_MODE == DMMU_M_FRAC_SAT_AT_BIT31
            && !OP_UNIT |=> acc0_r[39:31] == 9'h000 || acc0_r[39:31] == 9'h1ff;
    endproperty
    a_w32_range: assert property (p_w32_range) // RQ15
        else $error("Bit-31 format accumulator out of range.");

    property p_bus_wait;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("Bus access waited more than one cycle.");
endmodule
`default_nettype wire

// *** testbench/dmmu_rf_model.sv ***
// Data register file side of the multiply datapath: queues each result.
// Assumes results arrive as registered one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module dmmu_rf_model (
    // Clock.
    input wire logic clk,
    // Result write-back port.
    input wire logic res_valid,
    input wire logic res_half,
    input wire logic [31:0] res_data
);
    logic [32:0] got[$];

    // The half flag is queued with the data so stray upper bits are seen.
    always @(posedge clk) begin
        if (res_valid) begin
            got.push_back({res_half, res_data});
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench: directed corner cases, a seeded random mix,
// registers and the interrupt of the multiply datapath.
// Assumes the register slave answers through waitrequest in its own time.
`timescale 1ns/1ps
`default_nettype none
module tb_top import dmmu_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ov = 1'b0, ou = 1'b0, om = 1'b0, rq = 1'b0, wr = 1'b0;
    logic [1:0] ok = 2'h0, oa = 2'h0;
    logic [2:0] md = 3'h0;
    logic [5:0] ad = 6'h0;
    logic [31:0] s0 = 32'h0, s1 = 32'h0, wd = 32'h0, rd, rdat;
    logic rv, rh, wt, irq, ru;
    logic [32:0] eq[$];
    int err_total = 0;
    int num_checks = 0;
    // Rows: unit, mode, op, mixed, operands, accumulator afterwards.
    logic [87:0] tbl[12] = '{88'h0000_4000_4000_0020000000, 88'h0010_8000_8000_009fffffff,
        88'h1100_0001_0001_0000000001, 88'h1120_ffff_ffff_0000000000,
        88'h1200_ffff_0001_ffffffffff, 88'h1001_8000_ffff_ff80008000,
        88'h0001_8000_ffff_0000010000, 88'h0500_7fff_7fff_007ffe0002,
        88'h0510_7fff_7fff_007fffffff, 88'h1501_7fff_ffff_007ffe8001,
        88'h1511_7fff_ffff_007fffffff, 88'h1220_8000_7fff_00bfff7fff};

    always #5 clk = ~clk;

    dmmu_top dut (.CORE_CLK(clk), .NRST(nrst), .OP_VALID(ov), .OP_KIND(ok), .OP_MODE(md),
        .OP_ACC(oa), .OP_UNIT(ou), .OP_MIXED(om), .OP_SRC0(s0), .OP_SRC1(s1),
        .RES_VALID(rv), .RES_HALF(rh), .RES_UNIT(ru), .RES_DATA(rdat),
        .AVS_ADDRESS(ad), .AVS_READ(rq), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
        .AVS_READDATA(rd), .AVS_WAITREQUEST(wt), .IRQ(irq));
    dmmu_rf_model pm (.clk(clk), .res_valid(rv), .res_half(rh), .res_data(rdat));

    // ---------------------------------------------
    // Drivers, comparison and expectations
    // ---------------------------------------------
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Waitrequest is sampled at each rising edge before the slave's update
    // lands, so the request stands until the very edge that takes it.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        rq <= ~w;
        wr <= w;
        ad <= a;
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        rq <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic iss(input logic [1:0] k, input logic [2:0] m, input logic [1:0] a,
                       input logic u, input logic x, input logic [31:0] p, input logic [31:0] q);
        @(posedge clk);
        ov <= 1'b1;
        ok <= k;
        md <= m;
        oa <= a;
        ou <= u;
        om <= x;
        s0 <= p;
        s1 <= q;
    endtask

    task automatic idle;
        @(posedge clk);
        ov <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic res(input logic [32:0] e);
        chk(pm.got.size() > 0 ? pm.got.pop_front() : 'x, e);
    endtask

    task automatic acc(input logic u, input logic [39:0] e);
        logic [31:0] lo;
        bus(1'b0, u ? 6'h1c : 6'h14, 32'h0);
        lo = rd;
        bus(1'b0, u ? 6'h20 : 6'h18, 32'h0);
        chk({rd[7:0], lo}, e);
    endtask

    // Doubled integer product, clipped at the positive word limit.
    function automatic logic [32:0] dbl(input logic [15:0] p, input logic [15:0] q);
        longint v;
        v = longint'($signed(p)) * longint'($signed(q)) * 2;
        return {1'b0, (v > 2147483647) ? 32'h7fffffff : v[31:0]};
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #50us;
        err_total++;
        test_done;
    end

    initial begin
        logic [31:0] a, b, t;
        logic [87:0] r;
        void'($urandom(32'h51af));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, 6'h00, 32'h0);
        chk(rd, 40'h1);
        iss(DMMU_K_MUL16_HALF, 3'h3, 2'h0, 1'b0, 1'b0, 32'h40, 32'h100);
        idle;
        res({1'b1, 32'h7fff});
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'h3, 40'h3);
        iss(DMMU_K_MUL16_HALF, 3'h0, 2'h0, 1'b0, 1'b0, 32'h8000, 32'h8000);
        iss(DMMU_K_MUL16_HALF, 3'h4, 2'h0, 1'b1, 1'b1, 32'hffff, 32'hffff);
        iss(DMMU_K_MUL16_HALF, 3'h1, 2'h0, 1'b0, 1'b0, 32'hffff, 32'hffff);
        iss(DMMU_K_MUL16_HALF, 3'h3, 2'h0, 1'b0, 1'b0, 32'h3, 32'h5);
        iss(DMMU_K_MUL16_HALF, 3'h4, 2'h0, 1'b0, 1'b0, 32'h7fff, 32'h7fff);
        iss(DMMU_K_MUL16_HALF, 3'h4, 2'h0, 1'b0, 1'b0, 32'h280, 32'h100);
        idle;
        res({1'b1, 32'h7fff});
        res({1'b1, 32'hffff});
        res({1'b1, 32'hfffe});
        res({1'b1, 32'h1e});
        res({1'b1, 32'h3fff});
        res({1'b1, 32'h3});
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'h3, 40'h2);
        bus(1'b1, 6'h00, 32'h0);
        iss(DMMU_K_MUL16_HALF, 3'h4, 2'h0, 1'b1, 1'b0, 32'h280, 32'h100);
        idle;
        res({1'b1, 32'h2});
        chk(ru, 40'h1);
        $display("test half results done");
        bus(1'b0, 6'h08, 32'h0);
        chk(rd & 32'h1, 40'h1);
        chk(irq, 40'h0);
        bus(1'b1, 6'h10, 32'h1);
        @(negedge clk);
        chk(irq, 40'h1);
        bus(1'b1, 6'h0c, 32'h1);
        @(negedge clk);
        chk(irq, 40'h0);
        bus(1'b0, 6'h3c, 32'h0);
        chk(rd, 40'h0);
        $display("test interrupt done");
        foreach (tbl[i]) begin
            r = tbl[i];
            iss(DMMU_K_MACC, r[82:80], r[77:76], r[84], r[72],
                {16'h0, r[71:56]}, {16'h0, r[55:40]});
            idle;
            acc(r[84], r[39:0]);
        end
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'hf, 40'h6);
        bus(1'b0, 6'h08, 32'h0);
        chk(rd, 40'h6);
        $display("test accumulate done");
        for (int i = 0; i < 24; i++) begin
            a = $urandom;
            b = $urandom;
            if (i == 0) {a, b} = {32'h8000, 32'h8000};
            if (i == 22) {a, b} = {32'h3, 32'h3};
            t = a * b;
            eq.push_back(i[0] ? {1'b0, t} : dbl(a[15:0], b[15:0]));
            iss(i[0] ? DMMU_K_MUL32 : DMMU_K_MUL16_WORD, 3'h3, 2'h0, 1'b0, 1'b0, a, b);
        end
        iss(DMMU_K_MUL32, 3'h0, 2'h0, 1'b0, 1'b0, 32'hffffffff, 32'hffffffff);
        idle;
        eq.push_back(33'h1);
        foreach (eq[j]) res(eq[j]);
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'h3, 40'h2);
        acc(1'b0, 40'h007fffffff);
        acc(1'b1, 40'h00bfff7fff);
        $display("test word results done");
        test_done;
    end
endmodule
`default_nettype wire
